// *** design/mie_irq_vector.v ***
// How it works
// - One enable register gates every core source
// - Peripheral requests ORed into active-low line
// - Combined line drives core interrupt request
// - Timer and serial vectors, reset at zero
// - External-0 is peripheral line, vector 0003H
// - External-1 carries port-2 pins, vector 0013H
// - Bit 0 gates external interrupt 0
// - Bit 1 timer-0, bit 3 timer-1
// - Bit 2 gates external interrupt 1
// - Bit 4 gates serial port interrupt
// - Bit 5 gates timer-2 interrupt
// - Bit 7 global gate blocks all
// - Active-low port-2 inputs ORed for external-1
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "mie_consts.vh"
module mie_irq_vector #(
	parameter NUM_PERIPH = 8,
	parameter NUM_PORT = 8
)(
	// Clock and reset
	input wire clk_sys,
	input wire srst,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Interrupt sources, active high except as noted
	input wire [NUM_PERIPH-1:0] periph_irq,
	input wire [NUM_PORT-1:0] port2_pin_n,
	input wire tmr0_irq,
	input wire tmr1_irq,
	input wire tmr2_irq,
	input wire serial_irq,
	// Toward the core
	output reg combined_periph_irq_line,
	output reg port_pin_irq_line,
	output reg [5:0] core_irq_req,
	output reg [15:0] core_vector,
	output reg core_vector_valid,
	// Summary interrupt
	output wire irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [7:0] irq_enable_reg;
	reg [5:0] irq_status;
	reg [5:0] irq_mask;
	reg [3:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;

	wire global_irq_gate = irq_enable_reg[`MIE_BIT_GLOBAL];
	wire tmr2_irq_gate = irq_enable_reg[`MIE_BIT_TMR2];
	wire serial_irq_gate = irq_enable_reg[`MIE_BIT_SER];
	wire tmr1_irq_gate = irq_enable_reg[`MIE_BIT_TMR1];
	wire ext1_irq_gate = irq_enable_reg[`MIE_BIT_EXT1];
	wire tmr0_irq_gate = irq_enable_reg[`MIE_BIT_TMR0];
	wire ext0_irq_gate = irq_enable_reg[`MIE_BIT_EXT0];

	// ----------------------------------------
	// Source combining
	// ----------------------------------------
	// Any peripheral request pulls the shared line low
	wire next_combined_n = ~(|periph_irq);
	// Port-2 pins are active low, so any low pin raises a request
	wire port_req = ~(&port2_pin_n);
	// Raw requests in enable-bit order, ext0 taken as level low
	wire [5:0] raw_req;
	assign raw_req[`MIE_BIT_EXT0] = ~combined_periph_irq_line;
	assign raw_req[`MIE_BIT_TMR0] = tmr0_irq;
	assign raw_req[`MIE_BIT_EXT1] = port_req;
	assign raw_req[`MIE_BIT_TMR1] = tmr1_irq;
	assign raw_req[`MIE_BIT_SER] = serial_irq;
	assign raw_req[`MIE_BIT_TMR2] = tmr2_irq;
	// Individual gates, one per source
	wire [5:0] src_gate;
	assign src_gate[`MIE_BIT_EXT0] = ext0_irq_gate;
	assign src_gate[`MIE_BIT_TMR0] = tmr0_irq_gate;
	assign src_gate[`MIE_BIT_EXT1] = ext1_irq_gate;
	assign src_gate[`MIE_BIT_TMR1] = tmr1_irq_gate;
	assign src_gate[`MIE_BIT_SER] = serial_irq_gate;
	assign src_gate[`MIE_BIT_TMR2] = tmr2_irq_gate;
	// Global gate over all of them
	wire [5:0] next_req = raw_req & src_gate & {6{global_irq_gate}};

	// ----------------------------------------
	// Vector priority
	// ----------------------------------------
	// Fixed priority, lowest vector address first as in the core
	function [15:0] pick_vector;
		input [5:0] req;
		begin
			if (req[`MIE_BIT_EXT0])
				pick_vector = `MIE_VEC_EXT0;
			else if (req[`MIE_BIT_TMR0])
				pick_vector = `MIE_VEC_TMR0;
			else if (req[`MIE_BIT_EXT1])
				pick_vector = `MIE_VEC_EXT1;
			else if (req[`MIE_BIT_TMR1])
				pick_vector = `MIE_VEC_TMR1;
			else if (req[`MIE_BIT_SER])
				pick_vector = `MIE_VEC_SER;
			else if (req[`MIE_BIT_TMR2])
				pick_vector = `MIE_VEC_TMR2;
			else
				pick_vector = `MIE_VEC_RESET;
		end
	endfunction

	// ----------------------------------------
	// Core outputs
	// ----------------------------------------
	// Registered outputs toward the core
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			combined_periph_irq_line <= 1'b1;
			port_pin_irq_line <= 1'b1;
			core_irq_req <= 6'h00;
			core_vector <= `MIE_VEC_RESET;
			core_vector_valid <= 1'b0;
		end
		else
		begin
			combined_periph_irq_line <= next_combined_n;
			port_pin_irq_line <= ~port_req;
			core_irq_req <= next_req;
			core_vector <= pick_vector(next_req);
			core_vector_valid <= |next_req;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Mapped register offsets; everything else answers with an error
	function is_mapped;
		input [3:0] addr;
		begin
			is_mapped = (addr == `MIE_ADDR_ENABLE) | (addr == `MIE_ADDR_STATUS) |
				(addr == `MIE_ADDR_MASK) | (addr == `MIE_ADDR_VECTOR);
		end
	endfunction

	// Address and data are caught independently, in either order
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire = s_axi_wvalid & s_axi_wready;
	wire have_aw = aw_held | aw_fire;
	wire have_w = w_held | w_fire;
	wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_go = have_aw & have_w & ~s_axi_bvalid;
	wire wr_lane0 = wr_go & wr_strb[0];
	wire wr_hit = is_mapped(wr_addr);

	// ----------------------------------------
	// Register strobes, status and mask
	// ----------------------------------------
	// One strobe per writable register; the data sit in lane 0
	wire wr_enable = wr_lane0 & (wr_addr == `MIE_ADDR_ENABLE);
	wire wr_status = wr_lane0 & (wr_addr == `MIE_ADDR_STATUS);
	wire wr_mask = wr_lane0 & (wr_addr == `MIE_ADDR_MASK);

	// Sticky event flags; a new event beats a clear in the same cycle
	wire [5:0] w1c = wr_status ? wr_data[5:0] : 6'h00;
	wire [5:0] next_status = (irq_status & ~w1c) | (next_req & ~core_irq_req);
	assign irq = |(irq_status & irq_mask);

	// Status records rising gated requests only
	always @(posedge clk_sys)
	begin
		if (srst)
			irq_status <= 6'h00;
		else
			irq_status <= next_status;
	end

	// Mask shares the status layout
	always @(posedge clk_sys)
	begin
		if (srst)
			irq_mask <= 6'h00;
		else if (wr_mask)
			irq_mask <= wr_data[5:0] & `MIE_SRC_MASK;
	end

	// Enable register; reserved bit 6 never stores a one
	always @(posedge clk_sys)
	begin
		if (srst)
			irq_enable_reg <= `MIE_ENABLE_RESET;
		else if (wr_enable)
			irq_enable_reg <= wr_data[7:0] & `MIE_ENABLE_WMASK;
	end

	// ----------------------------------------
	// Write handshake
	// ----------------------------------------
	// Response waits for both halves, so a lone half is parked
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MIE_RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
			end
			else
			begin
				aw_held <= have_aw;
				w_held <= have_w;
				if (s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read mux; unmapped reads answer zero with an error
	reg [31:0] rd_val;
	reg rd_hit;
	always @*
	begin
		rd_val = 32'h0000_0000;
		rd_hit = is_mapped(s_axi_araddr);
		case (s_axi_araddr)
			`MIE_ADDR_ENABLE: rd_val = {24'h000000, irq_enable_reg};
			`MIE_ADDR_STATUS: rd_val = {26'h0, irq_status};
			`MIE_ADDR_MASK: rd_val = {26'h0, irq_mask};
			`MIE_ADDR_VECTOR: rd_val = {15'h0000, core_vector_valid, core_vector};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read channel, one cycle to answer
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MIE_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? `MIE_RESP_OKAY : `MIE_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule
`default_nettype wire

// *** design/mie_consts.vh ***
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define MIE_ADDR_ENABLE 4'h0
`define MIE_ADDR_STATUS 4'h4
`define MIE_ADDR_MASK 4'h8
`define MIE_ADDR_VECTOR 4'hC
// ----------------------------------------
// Enable register fields and reset
// ----------------------------------------
`define MIE_BIT_EXT0 0
`define MIE_BIT_TMR0 1
`define MIE_BIT_EXT1 2
`define MIE_BIT_TMR1 3
`define MIE_BIT_SER 4
`define MIE_BIT_TMR2 5
`define MIE_BIT_RSV 6
`define MIE_BIT_GLOBAL 7
`define MIE_ENABLE_WMASK 8'hBF
`define MIE_ENABLE_RESET 8'h00
`define MIE_SRC_MASK 6'h3F
// ----------------------------------------
// Code start addresses
// ----------------------------------------
`define MIE_VEC_RESET 16'h0000
`define MIE_VEC_EXT0 16'h0003
`define MIE_VEC_TMR0 16'h000B
`define MIE_VEC_EXT1 16'h0013
`define MIE_VEC_TMR1 16'h001B
`define MIE_VEC_SER 16'h0023
`define MIE_VEC_TMR2 16'h002B
// ----------------------------------------
// AXI response codes
// ----------------------------------------
`define MIE_RESP_OKAY 2'h0
`define MIE_RESP_SLVERR 2'h2
`endif

// *** verification/mie_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----
// Core-side sources
// ----
module mie_src_model (
	// Requests, core order
	input wire logic [5:0] src,
	// Peripheral and port pins
	output logic [7:0] periph_irq,
	output logic [7:0] port2_pin_n,
	// Timers and serial
	output logic tmr0_irq,
	output logic tmr1_irq,
	output logic tmr2_irq,
	output logic serial_irq
);
	// Held as levels, so firmware may treat ext0 as level-low
	assign periph_irq = src[0] ? 8'h10 : 8'h00;
	// Released pins rest high on pull-ups
	assign port2_pin_n = src[2] ? 8'hFE : 8'hFF;
	assign tmr0_irq = src[1];
	assign tmr1_irq = src[3];
	assign serial_irq = src[4];
	assign tmr2_irq = src[5];
endmodule
`default_nettype wire

// *** verification/mie_props.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mie_consts.vh"
module mie_props #(parameter NUM_PERIPH = 8, parameter NUM_PORT = 8) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Sources
	input wire logic [NUM_PERIPH-1:0] periph_irq,
	input wire logic [NUM_PORT-1:0] port2_pin_n,
	input wire logic tmr0_irq,
	input wire logic tmr1_irq,
	input wire logic tmr2_irq,
	input wire logic serial_irq,
	// Core side
	input wire logic combined_periph_irq_line,
	input wire logic port_pin_irq_line,
	input wire logic [5:0] core_irq_req,
	input wire logic [15:0] core_vector,
	input wire logic core_vector_valid
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// ----
	// Lines, requests, vectors
	// ----
	property p_or; !$past(srst) |-> combined_periph_irq_line == !(|$past(periph_irq)); endproperty
	a_or: assert property (p_or) else $error("peripheral line wrong");
	property p_pin; !$past(srst) |-> port_pin_irq_line == &$past(port2_pin_n); endproperty
	a_pin: assert property (p_pin) else $error("port line wrong");
	property p_e0; core_irq_req[0] |-> !$past(combined_periph_irq_line); endproperty
	a_e0: assert property (p_e0) else $error("ext0 request without line");
	property p_t0; core_irq_req[1] |-> $past(tmr0_irq); endproperty
	a_t0: assert property (p_t0) else $error("timer0 request without source");
	property p_e1; core_irq_req[2] |-> !(&$past(port2_pin_n)); endproperty
	a_e1: assert property (p_e1) else $error("ext1 request without pins");
	property p_t1; core_irq_req[3] |-> $past(tmr1_irq); endproperty
	a_t1: assert property (p_t1) else $error("timer1 request without source");
	property p_sr; core_irq_req[4] |-> $past(serial_irq); endproperty
	a_sr: assert property (p_sr) else $error("serial request without source");
	property p_t2; core_irq_req[5] |-> $past(tmr2_irq); endproperty
	a_t2: assert property (p_t2) else $error("timer2 request without source");
	property p_val; core_vector_valid == |core_irq_req; endproperty
	a_val: assert property (p_val) else $error("valid differs from requests");
	property p_v0; core_irq_req[0] |-> core_vector == `MIE_VEC_EXT0; endproperty
	a_v0: assert property (p_v0) else $error("ext0 vector wrong");
	property p_none; !core_vector_valid |-> core_vector == `MIE_VEC_RESET; endproperty
	a_none: assert property (p_none) else $error("idle vector wrong");
endmodule
bind mie_irq_vector mie_props #(.NUM_PERIPH(NUM_PERIPH), .NUM_PORT(NUM_PORT)) u_props (.*);
`default_nettype wire

// *** verification/mie_irq_vector_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mie_consts.vh"
module mie_irq_vector_tb;
	logic clk_sys = 1'h0, srst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_arready;
	logic s_axi_bvalid, s_axi_rvalid, combined_periph_irq_line, port_pin_irq_line, core_vector_valid, irq;
	logic tmr0_irq, tmr1_irq, tmr2_irq, serial_irq;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0] periph_irq, port2_pin_n;
	logic [5:0] src = 6'h00, core_irq_req;
	logic [15:0] core_vector;
	int fails = 0, check_count = 0, cyc = 0;
	// Rows: enable, sources, gated requests, vector
	logic [35:0] rows [12] = '{{8'h00, 6'h3F, 6'h00, 16'h0000}, {8'h3F, 6'h3F, 6'h00, 16'h0000},
		{8'hBF, 6'h3F, 6'h3F, 16'h0003}, {8'h81, 6'h01, 6'h01, 16'h0003}, {8'h82, 6'h02, 6'h02, 16'h000B},
		{8'h84, 6'h04, 6'h04, 16'h0013}, {8'h88, 6'h08, 6'h08, 16'h001B}, {8'h90, 6'h10, 6'h10, 16'h0023},
		{8'hA0, 6'h20, 6'h20, 16'h002B}, {8'hBE, 6'h01, 6'h00, 16'h0000}, {8'h9F, 6'h3C, 6'h1C, 16'h0013},
		{8'hC0, 6'h3F, 6'h00, 16'h0000}};
	mie_irq_vector dut (.*);
	mie_src_model u_src (.*);
	always #5 clk_sys = ~clk_sys;
	// Hang guard, far above the expected run
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			fails++;
			stop_test();
		end
	end
	// ----
	// Bus and check tasks
	// ----
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw = 1'h1;
		logic w = 1'h1;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw || w)
		begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge clk_sys);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys);
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'h0;
		rdr(`MIE_ADDR_ENABLE);
		chk("enable reset", 32'h0, rd);
		foreach (rows[i])
		begin
			wr(`MIE_ADDR_ENABLE, {24'h0, rows[i][35:28]});
			src <= rows[i][27:22];
			repeat (3) @(posedge clk_sys);
			chk("request", {26'h0, rows[i][21:16]}, {26'h0, core_irq_req});
			chk("vector", {16'h0, rows[i][15:0]}, {16'h0, core_vector});
			chk("vector valid", {31'h0, |rows[i][21:16]}, {31'h0, core_vector_valid});
			chk("periph line", {31'h0, !rows[i][22]}, {31'h0, combined_periph_irq_line});
			chk("port line", {31'h0, !rows[i][24]}, {31'h0, port_pin_irq_line});
		end
		wr(`MIE_ADDR_ENABLE, 32'hFF);
		rdr(`MIE_ADDR_ENABLE);
		chk("reserved bit", 32'hBF, rd);
		src <= 6'h00;
		wr(`MIE_ADDR_ENABLE, 32'h82);
		wr(`MIE_ADDR_STATUS, 32'h3F);
		wr(`MIE_ADDR_MASK, 32'h00);
		src <= 6'h02;
		repeat (3) @(posedge clk_sys);
		chk("masked irq", 32'h0, {31'h0, irq});
		rdr(`MIE_ADDR_VECTOR);
		chk("vector reg", 32'h0001_000B, rd);
		src <= 6'h00;
		wr(`MIE_ADDR_MASK, 32'h02);
		chk("sticky irq", 32'h1, {31'h0, irq});
		rdr(`MIE_ADDR_STATUS);
		chk("status reg", 32'h2, rd);
		wr(`MIE_ADDR_STATUS, 32'h02);
		chk("cleared irq", 32'h0, {31'h0, irq});
		wr(4'h2, 32'hFF);
		chk("unmapped write", 32'h2, {30'h0, rsp});
		rdr(4'h2);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped rresp", 32'h2, {30'h0, rsp});
		// Reset in mid-run, with a source active
		wr(`MIE_ADDR_ENABLE, 32'h82);
		src <= 6'h02;
		repeat (3) @(posedge clk_sys);
		chk("pre-reset request", 32'h2, {26'h0, core_irq_req});
		srst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		chk("reset request", 32'h0, {26'h0, core_irq_req});
		srst <= 1'h0;
		rdr(`MIE_ADDR_ENABLE);
		chk("enable after reset", 32'h0, rd);
		stop_test();
	end
endmodule
`default_nettype wire
